// ---- rtl/cct_pkg.sv ----
// Purpose: shared constants and carriers for the CAN configuration block
// Assumes: registers sit on a 32-bit classic Wishbone bus, one word each
// Notes:   register indices are word indices; byte address is index * 4
package cct_pkg;
    // register word indices
    localparam logic [13:0] IDX_CONTROL   = 14'h1E00;
    localparam logic [13:0] IDX_STATUS    = 14'h1E01;
    localparam logic [13:0] IDX_SG_MASK   = 14'h1E06;
    localparam logic [13:0] IDX_EG_MASK   = 14'h1E08;
    localparam logic [13:0] IDX_M15_MASK  = 14'h1E0C;
    localparam logic [13:0] IDX_BT_QUANT  = 14'h1E3F;
    localparam logic [13:0] IDX_BT_SEGS   = 14'h1E4F;
    // control register bit positions and reset value
    localparam int          CTL_INIT      = 0;
    localparam int          CTL_IE        = 1;
    localparam int          CTL_SIE       = 2;
    localparam int          CTL_EIE       = 3;
    localparam int          CTL_UNLOCK    = 6;
    localparam logic [7:0]  CTL_RESET     = 8'h01;
    localparam logic [7:0]  CTL_WMASK     = 8'h4F;
    // pending bits: error, status change, object
    localparam int          PND_ERR       = 0;
    localparam int          PND_STAT      = 1;
    localparam int          PND_OBJ       = 2;
    // status register bit positions
    localparam int          ST_BUSOFF     = 4;
    localparam int          ST_BUSON      = 5;
    // standard mask reserved bits read zero
    localparam logic [15:0] SG_VALID      = 16'hE0FF;
    localparam logic [31:0] EXT_VALID     = 32'hF8FF_FFFF;
    // bus idle: 11 recessive bits, 128 runs after bus-off
    localparam logic [3:0]  IDLE_BITS     = 4'hB;
    localparam logic [7:0]  RECOV_RUNS    = 8'h80;
    localparam logic [4:0]  TRIPLE_EXTRA  = 5'h02;
    localparam int          NOBJ          = 15;
    localparam int          IDW           = 29;
    // bit timing carriers
    typedef struct packed {
        logic [1:0] resync_jump_width;
        logic [5:0] quantum_prescaler;
    } cct_btq_t;
    typedef struct packed {
        logic       triple_sample_select;
        logic [2:0] post_sample_segment;
        logic [3:0] pre_sample_segment;
    } cct_bts_t;
    // bit phase, gray along sync -> seg1 -> seg2
    typedef enum logic [1:0] {
        PH_SYNC = 2'b00,
        PH_SEG1 = 2'b01,
        PH_SEG2 = 2'b11
    } cct_phase_t;
endpackage

// ---- rtl/cct_core.sv ----
// Purpose: CAN control, bit timing and acceptance mask block
// Assumes: classic Wishbone slave, 32-bit data; error counters,
//          frame engine and message objects live outside
// Notes:   ack comes one cycle after a request, for any address
// Contract
// - bit timing writes need unlock bit set
// - error enable gates bus-off and warning
// - status enable gates rx, tx, error-code change
// - global gate needs source enable too
// - gate clear still updates pending bits
// - reset sets init, keeping off bus
// - after init clear wait eleven recessive bits
// - init set halts reception and transmission
// - powerdown aborts transmission at once
// - counter at 256 flags bus-off, floats transmit
// - jump width is field plus one
// - resync keeps total bit time constant
// - quantum is two clocks times prescaler+1
// - triple sample uses majority, else single
// - triple sample lengthens first segment two
// - sample end of seg1, launch end seg2
// - bit is sync plus both segments
// - mask zero ignores bit, one must match
// - standard mask for 11-bit, extended 29-bit
// - objects 1-14 first, then object 15
// - standard mask field layout
// - extended mask field layout
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cct_core
    import cct_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [15:0]         adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // bus pins
    input  wire logic                rx_i,
    output logic                     tx_o,
    output logic                     tx_oe_n_o,
    // frame engine side
    input  wire logic                tx_bit_i,
    output logic                     sample_o,
    output logic                     rx_bit_o,
    output logic                     bit_start_o,
    output logic                     bus_on_o,
    input  wire logic                powerdown_i,
    // error and event sources
    input  wire logic [8:0]          rx_err_cnt_i,
    input  wire logic [8:0]          tx_err_cnt_i,
    output logic                     clear_err_cnt_o,
    input  wire logic                warn_ev_i,
    input  wire logic                rx_ok_ev_i,
    input  wire logic                tx_ok_ev_i,
    input  wire logic                lec_chg_ev_i,
    input  wire logic                obj_irq_ev_i,
    input  wire logic                obj_irq_en_i,
    output logic                     irq_o,
    // acceptance filter
    input  wire logic                id_valid_i,
    input  wire logic                id_ext_i,
    input  wire logic [IDW-1:0]      id_i,
    input  wire logic [NOBJ*IDW-1:0] obj_id_i,
    input  wire logic [NOBJ-1:0]     obj_ext_i,
    input  wire logic [NOBJ-1:0]     obj_en_i,
    output logic                     match_valid_o,
    output logic [3:0]               match_obj_o
);
    logic [7:0]  ctl;
    logic [15:0] sg_mask;
    logic [31:0] eg_mask;
    logic [31:0] m15_mask;
    cct_btq_t    btq;
    cct_bts_t    bts;
    logic [2:0]  pend;
    logic        busoff;
    logic        recov;
    logic        ack_q;
    logic [13:0] idx;
    logic        wr;
    logic        lock_ok;
    logic [31:0] wmask;

    // byte lanes to bit mask
    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // mask register image to identifier bit order
    function automatic logic [IDW-1:0] ext_map(input logic [31:0] m);
        return {m[7:0], m[15:8], m[23:16], m[31:27]};
    endfunction

    // masked identifier compare
    function automatic logic id_hit(input logic [IDW-1:0] a,
                                    input logic [IDW-1:0] b,
                                    input logic [IDW-1:0] m);
        return ((a ^ b) & m) == '0;
    endfunction

    assign idx     = adr_i[15:2];
    assign wr      = cyc_i & stb_i & we_i & ~ack_q;
    assign wmask   = lanes(sel_i);
    assign lock_ok = ctl[CTL_UNLOCK];
    assign ack_o   = ack_q;

    // single-cycle ack, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    // read mux, unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~we_i & ~ack_q) begin
            case (idx)
                IDX_CONTROL:  dat_o <= {24'h00_0000, ctl};
                IDX_STATUS:   dat_o <= {26'h000_0000, bus_on_o, busoff,
                                        1'b0, pend};
                IDX_SG_MASK:  dat_o <= {16'h0000, sg_mask};
                IDX_EG_MASK:  dat_o <= eg_mask;
                IDX_M15_MASK: dat_o <= m15_mask;
                IDX_BT_QUANT: dat_o <= {24'h00_0000, btq};
                IDX_BT_SEGS:  dat_o <= {24'h00_0000, bts};
                default:      dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // control register; hardware bus-off set wins over a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl <= CTL_RESET;
        end else begin
            if (wr && idx == IDX_CONTROL && sel_i[0]) begin
                ctl <= dat_i[7:0] & CTL_WMASK;
            end
            if (rx_err_cnt_i[8] | tx_err_cnt_i[8]) begin
                ctl[CTL_INIT] <= 1'b1;
            end
        end
    end

    // mask registers, reserved bits kept zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sg_mask  <= 16'h0000;
            eg_mask  <= 32'h0000_0000;
            m15_mask <= 32'h0000_0000;
        end else if (wr) begin
            if (idx == IDX_SG_MASK) begin
                sg_mask <= ((sg_mask & ~wmask[15:0]) |
                            (dat_i[15:0] & wmask[15:0])) & SG_VALID;
            end
            if (idx == IDX_EG_MASK) begin
                eg_mask <= ((eg_mask & ~wmask) | (dat_i & wmask)) & EXT_VALID;
            end
            if (idx == IDX_M15_MASK) begin
                m15_mask <= ((m15_mask & ~wmask) | (dat_i & wmask)) & EXT_VALID;
            end
        end
    end

    // bit timing registers, writable only while unlocked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            btq <= 8'h00;
            bts <= 8'h00;
        end else if (wr && lock_ok && sel_i[0]) begin
            if (idx == IDX_BT_QUANT) begin
                btq <= dat_i[7:0];
            end
            if (idx == IDX_BT_SEGS) begin
                bts <= dat_i[7:0];
            end
        end
    end

    // pending bits: events set even with gate clear, set beats clear
    logic       busoff_ev;
    logic [2:0] pend_set;
    logic [2:0] pend_clr;
    assign busoff_ev = (rx_err_cnt_i[8] | tx_err_cnt_i[8]) & ~busoff;
    assign pend_set  = {obj_irq_ev_i,
                        rx_ok_ev_i | tx_ok_ev_i | lec_chg_ev_i,
                        busoff_ev | warn_ev_i};
    assign pend_clr  = (wr && idx == IDX_STATUS && sel_i[0]) ? dat_i[2:0]
                                                             : 3'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= 3'h0;
        end else begin
            pend <= (pend & ~pend_clr) | pend_set;
        end
    end

    // interrupt: global gate and source enable both needed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= ctl[CTL_IE] &
                     ((pend[PND_ERR] & ctl[CTL_EIE]) |
                      (pend[PND_STAT] & ctl[CTL_SIE]) |
                      (pend[PND_OBJ] & obj_irq_en_i));
        end
    end

    // three-flop input synchroniser with agreement filter
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_f;
    logic rx_f_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1  <= 1'b1;
            rx_s2  <= 1'b1;
            rx_s3  <= 1'b1;
            rx_f   <= 1'b1;
            rx_f_d <= 1'b1;
        end else begin
            rx_s1  <= rx_i;
            rx_s2  <= rx_s1;
            rx_s3  <= rx_s2;
            rx_f_d <= rx_f;
            if (rx_s2 == rx_s3) begin
                rx_f <= rx_s3;
            end
        end
    end

    // quantum prescaler: period is 2*(prescaler+1) clocks
    logic [6:0] pre_cnt;
    logic [6:0] pre_top;
    logic       tq;
    assign pre_top = {btq.quantum_prescaler, 1'b1};
    assign tq      = (pre_cnt == pre_top);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= 7'h00;
        end else if (tq || pre_cnt > pre_top) begin
            pre_cnt <= 7'h00;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    // segment lengths in quanta, resync shift moves between them
    cct_phase_t phase;
    logic [4:0] q_cnt;
    logic [4:0] adj;
    logic [4:0] sjw_q;
    logic [4:0] seg1_len;
    logic [4:0] seg2_len;
    logic [4:0] next_adj;
    logic       last_q;
    logic       samp_pt;
    logic       samp_fin;
    assign sjw_q    = {3'h0, btq.resync_jump_width} + 5'h01;
    assign seg1_len = {1'b0, bts.pre_sample_segment} + 5'h01 + adj +
                      (bts.triple_sample_select ? TRIPLE_EXTRA : 5'h00);
    assign seg2_len = {2'h0, bts.post_sample_segment} + 5'h01 - adj;
    assign samp_fin = (phase == PH_SEG1) && (q_cnt == seg1_len - 5'h01);
    assign samp_pt  = samp_fin || (bts.triple_sample_select &&
                      (phase == PH_SEG1) && (q_cnt + TRIPLE_EXTRA >= seg1_len - 5'h01));
    assign last_q   = (phase == PH_SYNC) ||
                      (phase == PH_SEG1 && q_cnt == seg1_len - 5'h01) ||
                      (phase == PH_SEG2 && q_cnt == seg2_len - 5'h01);
    assign next_adj = (q_cnt + 5'h01 < sjw_q) ? q_cnt + 5'h01 : sjw_q;

    // bit phase sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= PH_SYNC;
            q_cnt <= 5'h00;
            adj   <= 5'h00;
        end else begin
            if (phase == PH_SEG1 && adj == 5'h00 && rx_f_d && !rx_f &&
                !samp_pt) begin
                adj <= next_adj;
            end
            if (tq) begin
                q_cnt <= last_q ? 5'h00 : q_cnt + 5'h01;
                case (phase)
                    PH_SYNC: begin
                        phase <= PH_SEG1;
                        adj   <= 5'h00;
                    end
                    PH_SEG1: if (last_q) begin
                        phase <= PH_SEG2;
                    end
                    PH_SEG2: if (last_q) begin
                        phase <= PH_SYNC;
                    end
                    default: phase <= PH_SYNC;
                endcase
            end
        end
    end

    // bus samples and majority vote
    logic [1:0] early;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            early    <= 2'h3;
            rx_bit_o <= 1'b1;
            sample_o <= 1'b0;
        end else begin
            sample_o <= tq & samp_fin;
            if (tq && samp_pt && !samp_fin) begin
                early <= {early[0], rx_f};
            end
            if (tq && samp_fin) begin
                rx_bit_o <= bts.triple_sample_select ?
                            ((early[1] & early[0]) | (early[1] & rx_f) |
                             (early[0] & rx_f)) : rx_f;
            end
        end
    end

    // transmit launch at end of second segment
    logic seg2_end;
    assign seg2_end = tq && phase == PH_SEG2 && last_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_o        <= 1'b1;
            bit_start_o <= 1'b0;
        end else begin
            bit_start_o <= seg2_end;
            if (!bus_on_o) begin
                tx_o <= 1'b1;
            end else if (seg2_end) begin
                tx_o <= tx_bit_i;
            end
        end
    end
    assign tx_oe_n_o = ~bus_on_o | powerdown_i | ctl[CTL_INIT];

    // bus-off flag and recovery start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busoff          <= 1'b0;
            recov           <= 1'b0;
            clear_err_cnt_o <= 1'b0;
        end else begin
            clear_err_cnt_o <= 1'b0;
            if (rx_err_cnt_i[8] | tx_err_cnt_i[8]) begin
                busoff <= 1'b1;
            end else if (busoff && !ctl[CTL_INIT]) begin
                busoff          <= 1'b0;
                recov           <= 1'b1;
                clear_err_cnt_o <= 1'b1;
            end else if (bus_on_o) begin
                recov <= 1'b0;
            end
        end
    end

    // idle detection before joining the bus
    logic [3:0] idle_cnt;
    logic [7:0] run_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_on_o <= 1'b0;
            idle_cnt <= 4'h0;
            run_cnt  <= 8'h00;
        end else if (ctl[CTL_INIT] || busoff) begin
            bus_on_o <= 1'b0;
            idle_cnt <= 4'h0;
            run_cnt  <= 8'h00;
        end else if (!bus_on_o && sample_o) begin
            if (!rx_bit_o) begin
                idle_cnt <= 4'h0;
            end else if (idle_cnt == IDLE_BITS - 4'h1) begin
                idle_cnt <= 4'h0;
                if (!recov || run_cnt == RECOV_RUNS - 8'h01) begin
                    bus_on_o <= 1'b1;
                end else begin
                    run_cnt <= run_cnt + 8'h01;
                end
            end else begin
                idle_cnt <= idle_cnt + 4'h1;
            end
        end
    end

    // acceptance filter: global mask for 1-14, object 15 last
    logic [IDW-1:0] sg_map;
    logic [IDW-1:0] g_mask;
    logic [NOBJ-1:0] hit;
    assign sg_map = {sg_mask[7:0], sg_mask[15:13], 18'h0_0000};
    assign g_mask = id_ext_i ? ext_map(eg_mask) : sg_map;
    genvar gi;
    generate
        for (gi = 0; gi < NOBJ; gi++) begin : g_obj
            logic [IDW-1:0] m;
            assign m = (gi == NOBJ - 1) ? (g_mask & ext_map(m15_mask))
                                        : g_mask;
            assign hit[gi] = obj_en_i[gi] && (obj_ext_i[gi] == id_ext_i) &&
                             id_hit(id_i, obj_id_i[gi*IDW +: IDW], m);
        end
    endgenerate

    // lowest matching object wins; 15 only when none of 1-14
    logic [3:0] next_obj;
    always_comb begin
        next_obj = 4'h0;
        for (int i = NOBJ - 2; i >= 0; i--) begin
            if (hit[i]) begin
                next_obj = 4'(i + 1);
            end
        end
        if (next_obj == 4'h0 && hit[NOBJ-1]) begin
            next_obj = 4'(NOBJ);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_valid_o <= 1'b0;
            match_obj_o   <= 4'h0;
        end else begin
            match_valid_o <= id_valid_i;
            if (id_valid_i) begin
                match_obj_o <= next_obj;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_bt_locked;
        wr && !lock_ok && (idx == IDX_BT_QUANT || idx == IDX_BT_SEGS)
            |=> $stable(btq) && $stable(bts);
    endproperty
    a_bt_locked: assert property (p_bt_locked) else $error("timing write leaked");
    property p_bt_open;
        wr && lock_ok && sel_i[0] && idx == IDX_BT_SEGS |=> bts == $past(dat_i[7:0]);
    endproperty
    a_bt_open: assert property (p_bt_open) else $error("timing write lost");
    property p_err_gate;
        irq_o && $past(pend) == 3'h1 |-> $past(ctl[CTL_EIE]);
    endproperty
    a_err_gate: assert property (p_err_gate) else $error("error irq ungated");
    property p_stat_gate;
        irq_o && $past(pend) == 3'h2 |-> $past(ctl[CTL_SIE]);
    endproperty
    a_stat_gate: assert property (p_stat_gate) else $error("status irq ungated");
    property p_global_gate;
        irq_o |-> $past(ctl[CTL_IE]);
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("irq without gate");
    property p_pend_no_gate;
        rx_ok_ev_i && !ctl[CTL_IE] |=> pend[PND_STAT] && !irq_o;
    endproperty
    a_pend_no_gate: assert property (p_pend_no_gate) else $error("pending lost");
    property p_init_off;
        ctl[CTL_INIT] |-> tx_oe_n_o ##1 !bus_on_o;
    endproperty
    a_init_off: assert property (p_init_off) else $error("on bus in init");
    property p_join;
        $rose(bus_on_o) |-> $past(rx_bit_o) && $past(idle_cnt) == IDLE_BITS - 4'h1;
    endproperty
    a_join: assert property (p_join) else $error("joined without idle");
    property p_pdown;
        powerdown_i |-> tx_oe_n_o;
    endproperty
    a_pdown: assert property (p_pdown) else $error("driving in powerdown");
    property p_busoff;
        tx_err_cnt_i[8] |=> busoff && ctl[CTL_INIT] ##1 tx_oe_n_o;
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off missed");
    property p_tq_space;
        tq && btq.quantum_prescaler == 6'h00 |=> !tq ##1 tq;
    endproperty
    a_tq_space: assert property (p_tq_space) else $error("quantum period wrong");

    c_join:   cover property ($rose(bus_on_o));
    c_triple: cover property (sample_o && bts.triple_sample_select);
    c_obj15:  cover property (match_valid_o && match_obj_o == 4'hF);
    c_resync: cover property ($rose(adj != 5'h00));
endmodule
`default_nettype wire

// ---- verif/cct_bus_node.sv ----
// Purpose: far-side node on the CAN bus, wired-and with the device
// Assumes: recessive is 1; a pull-up holds the bus recessive when idle
// Notes:   dom_i lets the bench force a dominant level
`timescale 1ns/100ps
`default_nettype none
module cct_bus_node (
    // device pins
    input  wire logic tx_i,
    input  wire logic tx_oe_n_i,
    // bench control
    input  wire logic dom_i,
    // resolved bus level
    output logic      rx_o
);
    // a floated transmitter leaves the pull-up in charge
    assign rx_o = (tx_oe_n_i | tx_i) & ~dom_i;
endmodule
`default_nettype wire

// ---- verif/can_config_timing_filter_test.sv ----
// Purpose: register, interrupt, bus join and filter checks of cct_core
// Assumes: one wishbone request at a time; the master waits for ack
// Notes:   quantum 2 clocks, bit 8 quanta, so 16 clocks a bit
`timescale 1ns/100ps
`default_nettype none
module can_config_timing_filter_test;
    import cct_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, rx_i, tx_o, tx_oe_n_o;
    logic ack_o, bit_start_o, bus_on_o, irq_o, match_valid_o, powerdown_i = 0;
    logic obj_irq_en_i = 0, id_valid_i = 0;
    logic [15:0] adr_i = 0;
    logic [3:0] sel_i = 4'hF, match_obj_o;
    logic [4:0] ev = 0;
    logic [8:0] tx_err = 9'h000;
    logic [31:0] dat_i = 0, dat_o, q;
    logic [IDW-1:0] id_i = 0;
    logic [NOBJ*IDW-1:0] obj_id_i = 0;
    logic [NOBJ-1:0] obj_en_i = 0;
    int bad_count = 0, samples_checked = 0, n, k;
    // device and far-side node
    cct_core u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .rx_i, .tx_o, .tx_oe_n_o, .tx_bit_i(1'h1), .sample_o(), .rx_bit_o(),
        .bit_start_o, .bus_on_o, .powerdown_i, .rx_err_cnt_i(9'h000), .tx_err_cnt_i(tx_err),
        .clear_err_cnt_o(), .warn_ev_i(ev[0]), .rx_ok_ev_i(ev[1]), .tx_ok_ev_i(ev[2]),
        .lec_chg_ev_i(ev[3]), .obj_irq_ev_i(ev[4]), .obj_irq_en_i, .irq_o, .id_valid_i,
        .id_ext_i(1'h0), .id_i, .obj_id_i, .obj_ext_i(15'h0000), .obj_en_i, .match_valid_o,
        .match_obj_o);
    cct_bus_node u_node (.tx_i(tx_o), .tx_oe_n_i(tx_oe_n_o), .dom_i(1'h0), .rx_o(rx_i));
    // 100 ns clock
    always #50 clk_i = ~clk_i;
    task automatic final_report;
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    // classic cycle: hold until ack is seen at an edge, then release
    task automatic bus(input logic w, input logic [13:0] i, input logic [31:0] d);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {i, 2'h0};
        dat_i <= d;
        @(posedge clk_i);
        for (n = 0; n < 20 && ack_o !== 1'h1; n++) @(posedge clk_i);
        if (n == 20) begin
            bad_count++;
            final_report();
        end
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    // clocks from one bit launch to the next, left in n
    task automatic period;
        for (n = 0; n < 50 && bit_start_o !== 1'h1; n++) @(negedge clk_i);
        @(negedge clk_i);
        for (n = 1; n < 50 && bit_start_o !== 1'h1; n++) @(negedge clk_i);
    endtask
    task automatic pulse(input int b);
        ev[b] <= 1'h1;
        @(posedge clk_i);
        ev[b] <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic match(input logic [IDW-1:0] v, input logic [3:0] e);
        id_i <= v;
        id_valid_i <= 1'h1;
        @(posedge clk_i);
        id_valid_i <= 1'h0;
        @(negedge clk_i);
        chk(match_valid_o, 1'h1);
        chk(match_obj_o, e);
        @(posedge clk_i);
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        bus(1'h0, IDX_CONTROL, 32'h0);
        chk(q, 32'h01);
        chk(tx_oe_n_o, 1'h1);
        bus(1'h1, IDX_BT_SEGS, 32'hFF);
        bus(1'h0, IDX_BT_SEGS, 32'h0);
        chk(q, 32'h00);
        bus(1'h1, IDX_CONTROL, 32'h41);
        bus(1'h1, IDX_BT_QUANT, 32'h00);
        bus(1'h1, IDX_BT_SEGS, 32'h23);
        bus(1'h0, IDX_BT_SEGS, 32'h0);
        chk(q, 32'h23);
        bus(1'h1, IDX_SG_MASK, 32'hFFFFFFFF);
        bus(1'h0, IDX_SG_MASK, 32'h0);
        chk(q, 32'h0000E0FF);
        bus(1'h1, IDX_EG_MASK, 32'hFFFFFFFF);
        bus(1'h0, IDX_EG_MASK, 32'h0);
        chk(q, 32'hF8FFFFFF);
        // error enable off, then global gate and status enable both off
        bus(1'h1, IDX_CONTROL, 32'h03);
        pulse(0);
        chk(irq_o, 1'h0);
        bus(1'h1, IDX_CONTROL, 32'h09);
        pulse(1);
        chk(irq_o, 1'h0);
        bus(1'h0, IDX_STATUS, 32'h0);
        chk(q[1:0], 2'h3);
        bus(1'h1, IDX_STATUS, 32'h7);
        obj_irq_en_i <= 1'h1;
        for (k = 0; k < 5; k++) begin
            bus(1'h1, IDX_CONTROL, (k == 0) ? 32'h0B : 32'h07);
            pulse(k);
            chk(irq_o, 1'h1);
            bus(1'h1, IDX_CONTROL, 32'h01);
            chk(irq_o, 1'h0);
            bus(1'h1, IDX_STATUS, 32'h7);
        end
        // leave init and join after eleven idle bits
        bus(1'h1, IDX_CONTROL, 32'h00);
        for (n = 0; n < 400 && bus_on_o !== 1'h1; n++) @(negedge clk_i);
        chk(n >= 160 && n <= 176, 1'h1);
        period();
        chk(n, 16);
        chk(tx_oe_n_o, 1'h0);
        @(posedge clk_i);
        powerdown_i <= 1'h1;
        @(negedge clk_i);
        chk(tx_oe_n_o, 1'h1);
        @(posedge clk_i);
        powerdown_i <= 1'h0;
        bus(1'h1, IDX_CONTROL, 32'h01);
        chk(tx_oe_n_o, 1'h1);
        chk(bus_on_o, 1'h0);
        // error counter at 256 forces bus-off, init clear recovers
        tx_err <= 9'h100;
        @(posedge clk_i);
        tx_err <= 9'h000;
        @(posedge clk_i);
        bus(1'h0, IDX_STATUS, 32'h0);
        chk(q[4], 1'h1);
        bus(1'h1, IDX_CONTROL, 32'h00);
        bus(1'h0, IDX_STATUS, 32'h0);
        chk(q[4], 1'h0);
        // objects 2 and 15 share one standard id
        obj_id_i[IDW+:IDW] <= 29'h1FFC0000;
        obj_id_i[14*IDW+:IDW] <= 29'h1FFC0000;
        obj_en_i <= 15'h4002;
        match(29'h1FFC0000, 4'h2);
        match(29'h1FDC0000, 4'hF);
        bus(1'h1, IDX_SG_MASK, 32'hE0FE);
        match(29'h1FDC0000, 4'h2);
        // triple sampling adds two quanta to the bit
        bus(1'h1, IDX_CONTROL, 32'h41);
        bus(1'h1, IDX_BT_SEGS, 32'hA3);
        period();
        chk(n, 20);
        final_report();
    end
endmodule
`default_nettype wire
